// File: logic/pp2_pkg.sv
// Purpose: Constants and types for the page-two PHY configuration bank
// Assumes: Register index times four gives the APB byte address
// Notes: Indices keep the printed register numbers
package pp2_pkg;
    // Register indices, byte address is index * 4
    localparam logic [4:0] IDX_TX_AMP = 5'h10;
    localparam logic [4:0] IDX_EEE = 5'h11;
    localparam logic [4:0] IDX_MAC_TIMING = 5'h14;
    localparam logic [4:0] IDX_WAKE_LOW = 5'h15;
    localparam logic [4:0] IDX_PAGE_SEL = 5'h1f;
    localparam logic [4:0] IDX_PAGE_FIRST = 5'h10;
    localparam logic [15:0] PAGE_TWO = 16'h0002;
    localparam logic [15:0] PAGE_MAIN = 16'h0000;

    // Field positions
    localparam int TX100_LSB = 8;
    localparam int TX10_LSB = 4;
    localparam int TX10TE_LSB = 0;
    localparam int EEE_10TE_BIT = 15;
    localparam int LED_INV_LSB = 10;
    localparam int LINK_UP_BIT = 8;
    localparam int EEE100_BIT = 6;
    localparam int FORCE_LPI_BIT = 4;
    localparam int INH_TX_LPI_BIT = 3;
    localparam int INH_RX_LPI_BIT = 2;
    localparam int FAST_LINK_FAILURE_TWO_BIT = 15;
    localparam int SOF_BIT = 12;
    localparam int RXD_REV_BIT = 7;
    localparam int RX_DLY_LSB = 4;
    localparam int TXD_REV_BIT = 3;
    localparam int TX_DLY_LSB = 0;

    // Reset values
    localparam logic [3:0] TX100_RST = 4'h2;
    localparam logic [3:0] TX10_RST = 4'h8;
    localparam logic [3:0] TX10TE_RST = 4'he;
    localparam logic [1:0] LED_INV_RST = 2'h0;
    localparam logic [2:0] DLY_RST = 3'h0;
    localparam logic [15:0] WAKE_RST = 16'h0000;

    // Bits that software may write; the rest read back as zero, except read-only EEE status bits 8 and 6 (EEE_RMASK)
    localparam logic [15:0] TX_AMP_WMASK = 16'h0fff;
    localparam logic [15:0] EEE_WMASK = 16'h8c1c;
    localparam logic [15:0] EEE_RMASK = 16'h8d5c;
    localparam logic [15:0] TIMING_WMASK = 16'h90ff;

    // Delay code 000 ... 111 = 0.2 0.8 1.1 1.7 2.0 2.3 2.6 3.4 ns
    typedef logic [2:0] pp2_delay_t;

    typedef struct packed {
        logic [3:0] amp_100tx;
        logic [3:0] amp_10t;
        logic [3:0] amp_10te;
        logic eee_10te_en;
        logic fast_link_failure_two_en;
        logic sof_en;
        pp2_delay_t rx_clk_delay;
        pp2_delay_t tx_clk_delay;
        logic [15:0] wake_addr_low;
    } pp2_cfg_t;
endpackage

// File: logic/pp2_nibble_rev.sv
// Purpose: Optional bit-order reversal of a data nibble
// Assumes: Purely combinational, width fixed by parameter
// Notes: Bit i maps to bit W-1-i when reverse is set
`timescale 1ns/1ps
module pp2_nibble_rev #(
    parameter int W = 4
) (
    input wire logic [W-1:0] din, // Data in
    input wire logic reverse, // Swap bit order
    output logic [W-1:0] dout // Data out
);
    initial
    begin
        if (W < 2)
            $error("pp2_nibble_rev: W must be at least 2");
    end

    always_comb
    begin
        for (int i = 0; i < W; i++)
            dout[i] = reverse ? din[W-1-i] : din[i];
    end
endmodule // pp2_nibble_rev

// File: logic/pp2_regs.sv
// Purpose: Page-two PHY configuration registers behind an APB slave
// Assumes: pclk 50 MHz, presetn is the hardware reset
// Notes: soft_reset restores only the non-sticky fields
// Operation
// - Bits 11:8 hold sticky 100BASE-TX amplitude trim, reset 0010.
// - Bits 7:4 hold sticky 10BASE-T amplitude trim, reset 1000.
// - Bits 3:0 hold sticky 10BASE-Te amplitude trim, reset 1110.
// - Sticky bit 15 enables 10BASE-Te energy-efficient mode, default zero.
// - Sticky bits 11:10 invert indicator outputs, default active low.
// - Read-only bit 8 shows link up, bit 6 shows 100TX EEE.
// - Force bit 4 sends LPI on line and ignores MAC data.
// - Bit 3 in 100TX stops MAC LPI requests going out to the line; bit 4 still forces LPI.
// - Bit 2 in 100TX stops line LPI reaching the MAC.
// - Bit 15 enables fast-link-failure-two, not sticky, resets zero.
// - Sticky bit 12 enables start-of-frame indication, resets zero.
// - Sticky bit 7 reverses receive nibble toward the MAC.
// - Sticky bit 3 reverses transmit nibble from the MAC.
// - Fields 6:4 and 2:0 pick receive and transmit clock delays.
// - Sticky 16-bit register holds low wake address bytes, reset zero.
`timescale 1ns/1ps
module pp2_regs #(
    parameter int ADDR_W = 8,
    parameter int NIB_W = 4
) (
    input wire logic pclk, // APB clock
    input wire logic presetn, // Hardware reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic soft_reset, // Software reset pulse
    input wire logic link_up, // Link status from core
    input wire logic eee_100tx_on, // EEE active for 100TX
    input wire logic speed_100, // Link runs 100BASE-TX
    input wire logic [NIB_W-1:0] mac_txd, // Transmit nibble from MAC
    input wire logic mac_tx_lpi, // MAC requests LPI
    input wire logic [NIB_W-1:0] core_rxd, // Receive nibble from line
    input wire logic line_rx_lpi, // LPI seen on the line
    input wire logic [1:0] led_on, // Indicator requests, high=on
    output logic [NIB_W-1:0] line_txd, // Transmit nibble to line
    output logic line_tx_lpi, // LPI to the line
    output logic [NIB_W-1:0] mac_rxd, // Receive nibble to MAC
    output logic mac_rx_lpi, // LPI to the MAC
    output logic [1:0] led_pin, // Indicator pin levels
    output pp2_pkg::pp2_cfg_t cfg // Configuration to the core
);
    initial
    begin
        if (ADDR_W < 8)
            $error("pp2_regs: ADDR_W must be at least 8");
        if (NIB_W != 4)
            $error("pp2_regs: NIB_W must be 4");
    end

    // Register state
    logic [15:0] page_sel;
    logic [3:0] amp_100tx;
    logic [3:0] amp_10t;
    logic [3:0] amp_10te;
    logic eee_10te_en;
    logic [1:0] led_invert;
    logic force_lpi;
    logic inhibit_tx_lpi;
    logic inhibit_rx_lpi;
    logic fast_link_failure_two_en;
    logic sof_en;
    logic rxd_rev;
    logic txd_rev;
    pp2_pkg::pp2_delay_t rx_dly;
    pp2_pkg::pp2_delay_t tx_dly;
    logic [15:0] wake_low;
    logic link_q;
    logic eee100_q;
    logic err_q;

    // Bus decode
    logic [4:0] idx;
    logic aligned;
    logic on_page2;
    logic hit_amp;
    logic hit_eee;
    logic hit_tim;
    logic hit_wake;
    logic hit_page;
    logic mapped;
    logic setup;
    logic wr_en;
    logic [15:0] be_mask;
    logic [15:0] wdata;
    logic [15:0] next_amp_reg;
    logic [15:0] next_eee_reg;
    logic [15:0] next_tim_reg;
    logic [15:0] rd_val;
    logic [15:0] amp_reg;
    logic [15:0] eee_reg;
    logic [15:0] tim_reg;
    logic [NIB_W-1:0] tx_nib;
    logic [NIB_W-1:0] rx_nib;

    assign idx = paddr[6:2];
    assign aligned = (paddr[1:0] == 2'h0)
        && (paddr[ADDR_W-1:7] == '0);
    assign on_page2 = (page_sel == pp2_pkg::PAGE_TWO);
    assign hit_amp = on_page2 && (idx == pp2_pkg::IDX_TX_AMP);
    assign hit_eee = on_page2 && (idx == pp2_pkg::IDX_EEE);
    assign hit_tim = on_page2 && (idx == pp2_pkg::IDX_MAC_TIMING);
    assign hit_wake = on_page2 && (idx == pp2_pkg::IDX_WAKE_LOW);
    assign hit_page = (idx == pp2_pkg::IDX_PAGE_SEL);
    assign mapped = aligned
        && (hit_amp || hit_eee || hit_tim || hit_wake || hit_page);
    assign setup = psel && !penable;
    assign pready = psel && penable;
    assign pslverr = pready && err_q;
    assign wr_en = pready && pwrite && !err_q;
    assign be_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wdata = pwdata[15:0];

    // Assembled register images, reserved bits zero
    always_comb
    begin
        amp_reg = 16'h0000;
        amp_reg[pp2_pkg::TX100_LSB +: 4] = amp_100tx;
        amp_reg[pp2_pkg::TX10_LSB +: 4] = amp_10t;
        amp_reg[pp2_pkg::TX10TE_LSB +: 4] = amp_10te;
    end

    always_comb
    begin
        eee_reg = 16'h0000;
        eee_reg[pp2_pkg::EEE_10TE_BIT] = eee_10te_en;
        eee_reg[pp2_pkg::LED_INV_LSB +: 2] = led_invert;
        eee_reg[pp2_pkg::LINK_UP_BIT] = link_q;
        eee_reg[pp2_pkg::EEE100_BIT] = eee100_q;
        eee_reg[pp2_pkg::FORCE_LPI_BIT] = force_lpi;
        eee_reg[pp2_pkg::INH_TX_LPI_BIT] = inhibit_tx_lpi;
        eee_reg[pp2_pkg::INH_RX_LPI_BIT] = inhibit_rx_lpi;
    end

    always_comb
    begin
        tim_reg = 16'h0000;
        tim_reg[pp2_pkg::FAST_LINK_FAILURE_TWO_BIT] = fast_link_failure_two_en;
        tim_reg[pp2_pkg::SOF_BIT] = sof_en;
        tim_reg[pp2_pkg::RXD_REV_BIT] = rxd_rev;
        tim_reg[pp2_pkg::RX_DLY_LSB +: 3] = rx_dly;
        tim_reg[pp2_pkg::TXD_REV_BIT] = txd_rev;
        tim_reg[pp2_pkg::TX_DLY_LSB +: 3] = tx_dly;
    end

    // Merged write values; only writable bits and strobed lanes change
    always_comb
    begin
        next_amp_reg = (amp_reg & ~(be_mask & pp2_pkg::TX_AMP_WMASK))
            | (wdata & be_mask & pp2_pkg::TX_AMP_WMASK);
        next_eee_reg = (eee_reg & ~(be_mask & pp2_pkg::EEE_WMASK))
            | (wdata & be_mask & pp2_pkg::EEE_WMASK);
        next_tim_reg = (tim_reg & ~(be_mask & pp2_pkg::TIMING_WMASK))
            | (wdata & be_mask & pp2_pkg::TIMING_WMASK);
    end

    // Read mux
    always_comb
    begin
        rd_val = 16'h0000;
        if (hit_page)
            rd_val = page_sel;
        else if (hit_amp)
            rd_val = amp_reg;
        else if (hit_eee)
            rd_val = eee_reg & pp2_pkg::EEE_RMASK;
        else if (hit_tim)
            rd_val = tim_reg;
        else if (hit_wake)
            rd_val = wake_low;
        else
            rd_val = 16'h0000;
    end

    // Read data and error captured in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            err_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= {16'h0000, mapped ? rd_val : 16'h0000};
            err_q <= !mapped;
        end
    end

    // Status sampling
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_q <= 1'b0;
            eee100_q <= 1'b0;
        end
        else
        begin
            link_q <= link_up;
            eee100_q <= eee_100tx_on;
        end
    end

    // Page select; non-sticky
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            page_sel <= pp2_pkg::PAGE_MAIN;
        else if (soft_reset)
            page_sel <= pp2_pkg::PAGE_MAIN;
        else if (wr_en && hit_page)
            page_sel <= (page_sel & ~be_mask) | (wdata & be_mask);
    end

    // Amplitude trims, sticky
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            amp_100tx <= pp2_pkg::TX100_RST;
            amp_10t <= pp2_pkg::TX10_RST;
            amp_10te <= pp2_pkg::TX10TE_RST;
        end
        else if (wr_en && hit_amp)
        begin
            amp_100tx <= next_amp_reg[pp2_pkg::TX100_LSB +: 4];
            amp_10t <= next_amp_reg[pp2_pkg::TX10_LSB +: 4];
            amp_10te <= next_amp_reg[pp2_pkg::TX10TE_LSB +: 4];
        end
    end

    // Energy-efficient controls, sticky
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            eee_10te_en <= 1'b0;
            led_invert <= pp2_pkg::LED_INV_RST;
            force_lpi <= 1'b0;
            inhibit_tx_lpi <= 1'b0;
            inhibit_rx_lpi <= 1'b0;
        end
        else if (wr_en && hit_eee)
        begin
            eee_10te_en <= next_eee_reg[pp2_pkg::EEE_10TE_BIT];
            led_invert <= next_eee_reg[pp2_pkg::LED_INV_LSB +: 2];
            force_lpi <= next_eee_reg[pp2_pkg::FORCE_LPI_BIT];
            inhibit_tx_lpi <= next_eee_reg[pp2_pkg::INH_TX_LPI_BIT];
            inhibit_rx_lpi <= next_eee_reg[pp2_pkg::INH_RX_LPI_BIT];
        end
    end

    // Fast-link-failure-two enable, cleared by soft reset too
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fast_link_failure_two_en <= 1'b0;
        else if (soft_reset)
            fast_link_failure_two_en <= 1'b0;
        else if (wr_en && hit_tim)
            fast_link_failure_two_en <= next_tim_reg[pp2_pkg::FAST_LINK_FAILURE_TWO_BIT];
    end

    // Interface timing, sticky fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sof_en <= 1'b0;
            rxd_rev <= 1'b0;
            txd_rev <= 1'b0;
            rx_dly <= pp2_pkg::DLY_RST;
            tx_dly <= pp2_pkg::DLY_RST;
        end
        else if (wr_en && hit_tim)
        begin
            sof_en <= next_tim_reg[pp2_pkg::SOF_BIT];
            rxd_rev <= next_tim_reg[pp2_pkg::RXD_REV_BIT];
            txd_rev <= next_tim_reg[pp2_pkg::TXD_REV_BIT];
            rx_dly <= next_tim_reg[pp2_pkg::RX_DLY_LSB +: 3];
            tx_dly <= next_tim_reg[pp2_pkg::TX_DLY_LSB +: 3];
        end
    end

    // Wake address low word, sticky
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_low <= pp2_pkg::WAKE_RST;
        else if (wr_en && hit_wake)
            wake_low <= (wake_low & ~be_mask) | (wdata & be_mask);
    end

    // Nibble reversal on both MAC paths
    pp2_nibble_rev #(
        .W(NIB_W)
    ) u_tx_rev (
        .din(mac_txd),
        .reverse(txd_rev),
        .dout(tx_nib)
    );

    pp2_nibble_rev #(
        .W(NIB_W)
    ) u_rx_rev (
        .din(core_rxd),
        .reverse(rxd_rev),
        .dout(rx_nib)
    );

    // Transmit path toward the line
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_txd <= '0;
            line_tx_lpi <= 1'b0;
        end
        else if (force_lpi)
        begin
            // Generator drives LPI; MAC data dropped
            line_txd <= '0;
            line_tx_lpi <= 1'b1;
        end
        else
        begin
            line_txd <= tx_nib;
            line_tx_lpi <= mac_tx_lpi
                && !(inhibit_tx_lpi && speed_100);
        end
    end

    // Receive path toward the MAC
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mac_rxd <= '0;
            mac_rx_lpi <= 1'b0;
        end
        else
        begin
            mac_rxd <= rx_nib;
            mac_rx_lpi <= line_rx_lpi
                && !(inhibit_rx_lpi && speed_100);
        end
    end

    // Indicator pins: active low unless inverted
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            led_pin <= 2'h3;
        else
            led_pin <= ~led_on ^ led_invert;
    end

    // Configuration outputs to the core
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg <= '0;
        else
        begin
            cfg.amp_100tx <= amp_100tx;
            cfg.amp_10t <= amp_10t;
            cfg.amp_10te <= amp_10te;
            cfg.eee_10te_en <= eee_10te_en;
            cfg.fast_link_failure_two_en <= fast_link_failure_two_en;
            cfg.sof_en <= sof_en;
            cfg.rx_clk_delay <= rx_dly;
            cfg.tx_clk_delay <= tx_dly;
            cfg.wake_addr_low <= wake_low;
        end
    end
endmodule // pp2_regs

// File: testbench/pp2_regs_assertions.sv
// Purpose: Port-level checks for the page-two config bank
// Assumes: Bound to pp2_regs, one clock domain
// Notes: cfg trails the registers by one cycle
`timescale 1ns/1ps
module pp2_regs_assertions #(
    parameter int ADDR_W = 8,
    parameter int NIB_W = 4
) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // write
    input wire logic [ADDR_W-1:0] paddr, // address
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic soft_reset, // soft reset
    input wire logic speed_100, // 100TX link
    input wire logic [NIB_W-1:0] mac_txd, // tx in
    input wire logic mac_tx_lpi, // tx lpi in
    input wire logic [NIB_W-1:0] core_rxd, // rx in
    input wire logic line_rx_lpi, // rx lpi in
    input wire logic [1:0] led_on, // led requests
    input wire logic [NIB_W-1:0] line_txd, // tx out
    input wire logic line_tx_lpi, // tx lpi out
    input wire logic [NIB_W-1:0] mac_rxd, // rx out
    input wire logic mac_rx_lpi, // rx lpi out
    input wire logic [1:0] led_pin, // led pins
    input wire pp2_pkg::pp2_cfg_t cfg // config
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire acc = psel && penable;

    function automatic logic [NIB_W-1:0] rev(input logic [NIB_W-1:0] v);
        return {<<{v}};
    endfunction

    page_reachable_a: assert property (acc && paddr[6:0] == 7'h7c &&
        paddr[ADDR_W-1:7] == '0 |-> !pslverr)
        else $error("page select refused");
    upper_zero_a: assert property (acc && !pwrite |->
        prdata[31:16] == 16'h0) else $error("upper half not zero");
    amp_default_a: assert property ($rose(presetn) |=>
        cfg.amp_100tx == 4'h2 && cfg.amp_10t == 4'h8 &&
        cfg.amp_10te == 4'he) else $error("amp trims not default");
    led_default_a: assert property ($rose(presetn) |=>
        led_pin == ~$past(led_on)) else $error("led not active low");
    tx_nibble_a: assert property ($past(presetn) |->
        line_txd == $past(mac_txd) || line_txd == rev($past(mac_txd)) ||
        (line_tx_lpi && line_txd == '0)) else $error("tx nibble wrong");
    rx_nibble_a: assert property ($past(presetn) |->
        mac_rxd == $past(core_rxd) || mac_rxd == rev($past(core_rxd)))
        else $error("rx nibble wrong");
    rx_lpi_pass_a: assert property ($past(presetn) &&
        !$past(speed_100) |-> mac_rx_lpi == $past(line_rx_lpi))
        else $error("rx lpi not passed");
    tx_lpi_pass_a: assert property ($past(presetn) &&
        !$past(speed_100) && $past(mac_tx_lpi) |-> line_tx_lpi)
        else $error("tx lpi not passed");
    fast_link_failure_two_clear_a: assert property (soft_reset && !(acc && pwrite)
        |-> ##2 !cfg.fast_link_failure_two_en) else $error("link fail enable kept");
    sticky_keep_a: assert property (soft_reset && !psel &&
        !$past(psel) && $past(presetn) |=> $stable(cfg.amp_100tx) &&
        $stable(cfg.wake_addr_low) && $stable(cfg.sof_en))
        else $error("sticky field lost");
endmodule // pp2_regs_assertions

// File: testbench/pp2_apb_master.sv
// Purpose: APB master standing in for the management controller
// Assumes: Tasks are called just after a rising edge
// Notes: One idle cycle follows every transfer
`timescale 1ns/1ps
module pp2_apb_master #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk, // clock
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic [31:0] prdata, // read data
    output logic psel, // select
    output logic penable, // access
    output logic pwrite, // write
    output logic [ADDR_W-1:0] paddr, // address
    output logic [31:0] pwdata, // write data
    output logic [3:0] pstrb // strobes
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end

    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
        input logic [15:0] d, output logic [31:0] rd,
        output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        pstrb <= 4'h3;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~{16'h0, d};
        @(posedge pclk);
    endtask
endmodule // pp2_apb_master

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the page-two config bank
// Assumes: Master model drives APB, a queue holds the expected error and read data of every transfer
// Notes: Random wake values and nibbles, seed 34
`timescale 1ns/1ps
module testbench;
    logic pclk, presetn, soft_reset, link_up, eee_100tx_on, speed_100;
    logic mac_tx_lpi, line_rx_lpi, line_tx_lpi, mac_rx_lpi, err;
    logic psel, penable, pwrite, pready, pslverr;
    logic [3:0] mac_txd, core_rxd, line_txd, mac_rxd, pstrb;
    logic [1:0] led_on, led_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [32:0] nt;
    logic [32:0] notes[$];
    pp2_pkg::pp2_cfg_t cfg;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 34;
    int i;

    pp2_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .soft_reset(soft_reset), .link_up(link_up),
        .eee_100tx_on(eee_100tx_on), .speed_100(speed_100),
        .mac_txd(mac_txd), .mac_tx_lpi(mac_tx_lpi), .core_rxd(core_rxd),
        .line_rx_lpi(line_rx_lpi), .led_on(led_on), .line_txd(line_txd),
        .line_tx_lpi(line_tx_lpi), .mac_rxd(mac_rxd),
        .mac_rx_lpi(mac_rx_lpi), .led_pin(led_pin), .cfg(cfg));
    pp2_apb_master i_mst (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v,
        input logic e);
        notes.push_back({e, 32'h0});
        i_mst.xfer(1'b1, a, v, rd, err);
    endtask

    task automatic rdx(input logic [7:0] a, input logic [15:0] x,
        input logic e);
        notes.push_back({e, 16'h0, x});
        i_mst.xfer(1'b0, a, 16'h0, rd, err);
    endtask

    function automatic logic [3:0] rv(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction

    // Drive both nibbles and lpi inputs, compare registered outputs
    task automatic dp(input logic [3:0] t, input logic [3:0] r,
        input logic [1:0] l, input logic [3:0] et, input logic [3:0] er,
        input logic [1:0] el);
        mac_txd <= t;
        core_rxd <= r;
        {mac_tx_lpi, line_rx_lpi} <= l;
        repeat (2) @(posedge pclk);
        check(32'(line_txd), 32'(et));
        check(32'(mac_rxd), 32'(er));
        check(32'({line_tx_lpi, mac_rx_lpi}), 32'(el));
    endtask

    always @(posedge pclk)
        if (psel && penable && pready === 1'b1)
        begin
            nt = notes.pop_front();
            check(32'(pslverr), 32'(nt[32]));
            if (!pwrite)
                check(prdata, nt[31:0]);
        end

    initial
    begin
        #100000;
        n_mismatch++;
        complete_run;
    end

    initial
    begin
        presetn = 1'b0;
        soft_reset = 1'b0;
        link_up = 1'b0;
        eee_100tx_on = 1'b0;
        speed_100 = 1'b1;
        mac_txd = 4'h0;
        core_rxd = 4'h0;
        mac_tx_lpi = 1'b0;
        line_rx_lpi = 1'b0;
        led_on = 2'h1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check(32'({cfg.amp_100tx, cfg.amp_10t, cfg.amp_10te}),
            32'h28e);
        check(32'(led_pin), 32'h2);
        rdx(8'h40, 16'h0, 1'b1);
        rdx(8'h41, 16'h0, 1'b1);
        wr(8'h7c, 16'h0002, 1'b0);
        rdx(8'h40, 16'h028e, 1'b0);
        rdx(8'h44, 16'h0, 1'b0);
        rdx(8'h50, 16'h0, 1'b0);
        rdx(8'h54, 16'h0, 1'b0);
        rdx(8'h48, 16'h0, 1'b1);
        rdx(8'hc0, 16'h0, 1'b1);
        link_up <= 1'b1;
        eee_100tx_on <= 1'b1;
        wr(8'h40, 16'hffff, 1'b0);
        wr(8'h44, 16'hffff, 1'b0);
        wr(8'h50, 16'hffff, 1'b0);
        rdx(8'h40, 16'h0fff, 1'b0);
        rdx(8'h44, 16'h8d5c, 1'b0);
        rdx(8'h50, 16'h90ff, 1'b0);
        check(32'({cfg.eee_10te_en, cfg.fast_link_failure_two_en, cfg.sof_en}), 32'h7);
        dp(4'h1, 4'h2, 2'h3, 4'h0, 4'h4, 2'h2);
        check(32'(led_pin), 32'h1);
        wr(8'h44, 16'h000c, 1'b0);
        dp(4'h1, 4'h2, 2'h3, 4'h8, 4'h4, 2'h0);
        speed_100 <= 1'b0;
        dp(4'h1, 4'h2, 2'h3, 4'h8, 4'h4, 2'h3);
        for (i = 0; i < 8; i++)
        begin
            d = $random(seed);
            wr(8'h50, {9'h0, i[2:0], 1'b0, 3'(7 - i)}, 1'b0);
            wr(8'h54, d[15:0], 1'b0);
            check(32'({cfg.rx_clk_delay, cfg.tx_clk_delay}),
                32'({i[2:0], 3'(7 - i)}));
            rdx(8'h54, d[15:0], 1'b0);
            check(32'(cfg.wake_addr_low), 32'(d[15:0]));
            dp(d[19:16], d[23:20], 2'h0, d[19:16], d[23:20], 2'h0);
        end
        wr(8'h50, 16'h9000, 1'b0);
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        rdx(8'h50, 16'h0, 1'b1);
        wr(8'h7c, 16'h0002, 1'b0);
        rdx(8'h50, 16'h1000, 1'b0);
        rdx(8'h54, d[15:0], 1'b0);
        wr(8'h7c, 16'h0000, 1'b0);
        rdx(8'h54, 16'h0, 1'b1);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        wr(8'h7c, 16'h0002, 1'b0);
        rdx(8'h40, 16'h028e, 1'b0);
        rdx(8'h44, 16'h0140, 1'b0);
        complete_run;
    end
endmodule // testbench

bind pp2_regs pp2_regs_assertions #(.ADDR_W(ADDR_W), .NIB_W(NIB_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr),
    .soft_reset(soft_reset), .speed_100(speed_100), .mac_txd(mac_txd),
    .mac_tx_lpi(mac_tx_lpi), .core_rxd(core_rxd),
    .line_rx_lpi(line_rx_lpi), .led_on(led_on), .line_txd(line_txd),
    .line_tx_lpi(line_tx_lpi), .mac_rxd(mac_rxd), .mac_rx_lpi(mac_rx_lpi),
    .led_pin(led_pin), .cfg(cfg));
